// ==== mps_pkg.sv ====
// Overview of operation
// - With the debug bit set, commutation, demagnetisation and zero-crossing events go out on two debug pins, or commutation and update events in speed measurement mode.
// - Each compare channel U, V and W reaches its own PWM pin only while its output control bit is one.
// - In sensorless mode with no sampling delay and no on-time sampling, the off-time code gives a minimum off time of (code+1) times 2.5 us at 4 MHz, else none.
// - The sampling delay code waits code times 2.5 us at 4 MHz before sampling in the on time; zero samples in the off time while on_time_sampling_sel is clear.
// - A sample meant for the on time that falls into the following off time is dropped, and in the zero-crossing phase the sampling-out flag is set.
// - The sampling-out mask enables the interrupt for zero-crossing sampling only; demagnetisation sampling never raises it.
// - The sampling-out interrupt can only occur when a nonzero sampling delay is programmed.
// - The prescaler code divides the motor controller clock by one for 00, two for 01 and four for 10 or 11.
// - Reset loads the sampling configuration with 02h and the PWM and parity registers with zero.
// - Tacho edge code zero means position sensor or sensorless mode; any other code means speed sensor mode.
// - Tacho edge code 01 captures rising edges, 10 falling edges, 11 both edges.
// - Each parity bit selects a high level at zero and a low level at one, and all are ignored with three independent channels.
package mps_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] OFS_PWM       = 8'h00;
    localparam logic [7:0] OFS_CONF      = 8'h04;
    localparam logic [7:0] OFS_PAR       = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

    // =========================================================
    // field positions
    localparam int PWM_DBG_BIT   = 7;
    localparam int PWM_EN_W_BIT  = 6;
    localparam int PWM_EN_V_BIT  = 5;
    localparam int PWM_EN_U_BIT  = 4;
    localparam int PWM_OT_LSB    = 0;
    localparam int CONF_DS_LSB   = 4;
    localparam int CONF_FLAG_BIT = 3;
    localparam int CONF_MASK_BIT = 2;
    localparam int CONF_PSC_LSB  = 0;
    localparam int PAR_TES_LSB   = 6;
    localparam int PAR_OE_LSB    = 0;
    localparam int IRQ_LATE_BIT  = 0;

    // =========================================================
    // reset values
    localparam logic [7:0] PWM_RST  = 8'h00;
    localparam logic [7:0] CONF_RST = 8'h02;
    localparam logic [7:0] PAR_RST  = 8'h00;

    // =========================================================
    // timing: one code step of off time and delay
    localparam int UNIT_TIME_NS     = 2500;
    localparam int REF_PERIPH_KHZ   = 4000;
    localparam int UNIT_CYC         = (UNIT_TIME_NS * REF_PERIPH_KHZ + 999999) / 1000000;

    // =========================================================
    // carriers
    typedef struct packed {
        logic c_event;
        logic d_event;
        logic z_event;
        logic u_event;
    } mps_evt_type;

    typedef struct packed {
        logic sensor_mode_sel;
        logic on_time_sampling_sel;
        logic speed_meas_mode;
        logic three_channel_sel;
        logic z_phase;
    } mps_mode_type;

    // code steps to peripheral cycles
    function automatic logic [7:0] mps_units(input logic [4:0] n);
        return 8'(int'(n) * UNIT_CYC);
    endfunction : mps_units

endpackage : mps_pkg

// ==== mps_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_prescaler
    import mps_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] div_sel,
    output logic            tick
);

    logic [1:0] cnt_ff;
    logic       tick_ff;

    // =========================================================
    // free running divider
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 2'h0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_sel == 2'h0) | ((div_sel == 2'h1) & cnt_ff[0])
                     | (div_sel[1] & (cnt_ff == 2'h3));
        end
    end

    assign tick = tick_ff;

endmodule : mps_prescaler
`default_nettype wire

// ==== mps_tick_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_tick_timer
    import mps_pkg::*;
#(
    parameter int CNT_W = 8
)(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             tick,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    output logic                  busy,
    output logic                  done
);

    logic [CNT_W-1:0] cnt_ff;
    logic             done_ff;
    logic             busy_ff;

    // =========================================================
    // down counter in peripheral cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (tick && (cnt_ff != '0)) begin
            cnt_ff <= cnt_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= !load && tick && (cnt_ff == CNT_W'(1));
        end
    end

    // busy follows the next count, so it is a flop with no extra latency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_ff <= 1'b0;
        end else if (load) begin
            busy_ff <= (load_val != '0);
        end else begin
            busy_ff <= (cnt_ff != '0) && !(tick && (cnt_ff == CNT_W'(1)));
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;

endmodule : mps_tick_timer
`default_nettype wire

// ==== mps_top.sv ====
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module mps_top
    import mps_pkg::*;
#(
    parameter int CNT_W = 8
)(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire mps_evt_type   events,
    input  wire mps_mode_type  modes,
    input  wire logic          pwm_u_in,
    input  wire logic          pwm_v_in,
    input  wire logic          pwm_w_in,
    input  wire logic          pwm_on,
    output logic               phase_u_pwm_pin,
    output logic               phase_v_pwm_pin,
    output logic               phase_w_pwm_pin,
    output logic               debug_demag_pin,
    output logic               debug_zero_cross_pin,
    output logic               min_off_busy,
    output logic               z_sample_strobe,
    output logic               speed_sensor_mode,
    output logic               capture_rise_en,
    output logic               capture_fall_en,
    output logic      [5:0]    out_active_low,
    output logic               irq
);

    if (CNT_W < 8) begin : g_chk
        $error("CNT_W too small for the longest interval");
    end

    // =========================================================
    // registers
    logic [7:0]       pwm_ctrl_ff;
    logic [3:0]       ds_ff;
    logic             flag_ff;
    logic             mask_ff;
    logic [1:0]       presc_ff;
    logic [7:0]       par_ff;
    logic [7:0]       addr_ff;
    logic             wr_pend_ff;
    logic [31:0]      hrdata_ff;
    logic             hreadyout_ff;
    logic             pwm_on_q_ff;
    logic             phase_u_ff;
    logic             phase_v_ff;
    logic             phase_w_ff;
    logic             dbg_demag_ff;
    logic             dbg_zc_ff;
    logic             strobe_ff;
    logic             speed_ff;
    logic             rise_en_ff;
    logic             fall_en_ff;
    logic [5:0]       low_ff;
    logic             irq_ff;
    logic             nxt_flag;
    logic             acc_valid;
    logic             we_pwm;
    logic             we_conf;
    logic             we_par;
    logic             we_stat;
    logic             we_mask;
    logic             late_set;
    logic             late_clr;
    logic             periph_tick;
    logic             pwm_rise;
    logic             pwm_fall;
    logic             off_load;
    logic             dly_load;
    logic             off_busy;
    logic             dly_busy;
    logic             dly_done;
    logic [CNT_W-1:0] off_val;
    logic [CNT_W-1:0] dly_val;
    logic [7:0]       rd_val;

    // =========================================================
    // ahb-lite slave, zero wait states
    assign acc_valid = hsel && hready && htrans[1];
    assign we_pwm    = wr_pend_ff && (addr_ff == OFS_PWM);
    assign we_conf   = wr_pend_ff && (addr_ff == OFS_CONF);
    assign we_par    = wr_pend_ff && (addr_ff == OFS_PAR);
    assign we_stat   = wr_pend_ff && (addr_ff == OFS_IRQ_STAT);
    assign we_mask   = wr_pend_ff && (addr_ff == OFS_IRQ_MASK);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff    <= 8'h00;
            wr_pend_ff <= 1'b0;
        end else begin
            wr_pend_ff <= acc_valid && hwrite;
            if (acc_valid) begin
                addr_ff <= haddr[7:0];
            end
        end
    end

    always_comb begin
        unique case (haddr[7:0])
            OFS_PWM:      rd_val = pwm_ctrl_ff;
            OFS_CONF:     rd_val = {ds_ff, flag_ff, mask_ff, presc_ff};
            OFS_PAR:      rd_val = par_ff;
            OFS_IRQ_STAT: rd_val = {7'h00, flag_ff};
            OFS_IRQ_MASK: rd_val = {7'h00, mask_ff};
            default:      rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff    <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= (acc_valid && !hwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    // =========================================================
    // control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_ctrl_ff <= PWM_RST;
            par_ff      <= PAR_RST;
        end else begin
            if (we_pwm) begin
                pwm_ctrl_ff <= hwdata[7:0];
            end
            if (we_par) begin
                par_ff <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ds_ff    <= CONF_RST[CONF_DS_LSB+:4];
            mask_ff  <= CONF_RST[CONF_MASK_BIT];
            presc_ff <= CONF_RST[CONF_PSC_LSB+:2];
        end else begin
            if (we_conf) begin
                ds_ff    <= hwdata[CONF_DS_LSB+:4];
                mask_ff  <= hwdata[CONF_MASK_BIT];
                presc_ff <= hwdata[CONF_PSC_LSB+:2];
            end else if (we_mask) begin
                mask_ff <= hwdata[IRQ_LATE_BIT];
            end
        end
    end

    // =========================================================
    // sampling-out flag, set wins over clear
    assign late_set = dly_done && !pwm_on && modes.z_phase && (ds_ff != 4'h0);
    assign late_clr = (we_conf && hwdata[CONF_FLAG_BIT]) || (we_stat && hwdata[IRQ_LATE_BIT]);
    assign nxt_flag = late_set || (flag_ff && !late_clr);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= CONF_RST[CONF_FLAG_BIT];
            irq_ff  <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            irq_ff  <= flag_ff && mask_ff;
        end
    end

    // =========================================================
    // peripheral clock and timers
    mps_prescaler u_psc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .div_sel (presc_ff),
        .tick    (periph_tick)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_on_q_ff <= 1'b0;
        end else begin
            pwm_on_q_ff <= pwm_on;
        end
    end

    assign pwm_rise = pwm_on && !pwm_on_q_ff;
    assign pwm_fall = !pwm_on && pwm_on_q_ff;
    assign off_load = pwm_fall && !modes.sensor_mode_sel && !modes.on_time_sampling_sel
                    && (ds_ff == 4'h0);
    assign dly_load = pwm_rise && (ds_ff != 4'h0);
    assign off_val  = CNT_W'(mps_units({1'b0, pwm_ctrl_ff[PWM_OT_LSB+:4]} + 5'h01));
    assign dly_val  = CNT_W'(mps_units({1'b0, ds_ff}));

    mps_tick_timer #(.CNT_W(CNT_W)) u_off (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .tick     (periph_tick),
        .load     (off_load),
        .load_val (off_val),
        .busy     (off_busy),
        .done     ()
    );

    mps_tick_timer #(.CNT_W(CNT_W)) u_dly (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .tick     (periph_tick),
        .load     (dly_load),
        .load_val (dly_val),
        .busy     (dly_busy),
        .done     (dly_done)
    );

    // =========================================================
    // sample strobe, on-time or off-time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_ff <= 1'b0;
        end else begin
            strobe_ff <= (dly_done && pwm_on)
                       || (pwm_fall && (ds_ff == 4'h0) && !modes.on_time_sampling_sel);
        end
    end

    // =========================================================
    // pwm pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_u_ff <= 1'b0;
            phase_v_ff <= 1'b0;
            phase_w_ff <= 1'b0;
        end else begin
            phase_u_ff <= pwm_u_in && pwm_ctrl_ff[PWM_EN_U_BIT];
            phase_v_ff <= pwm_v_in && pwm_ctrl_ff[PWM_EN_V_BIT];
            phase_w_ff <= pwm_w_in && pwm_ctrl_ff[PWM_EN_W_BIT];
        end
    end

    // =========================================================
    // debug pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_demag_ff <= 1'b0;
            dbg_zc_ff    <= 1'b0;
        end else if (!pwm_ctrl_ff[PWM_DBG_BIT]) begin
            dbg_demag_ff <= 1'b0;
            dbg_zc_ff    <= 1'b0;
        end else if (modes.speed_meas_mode) begin
            dbg_demag_ff <= dbg_demag_ff ^ events.c_event;
            dbg_zc_ff    <= dbg_zc_ff ^ events.u_event;
        end else begin
            if (events.c_event) begin
                dbg_demag_ff <= 1'b1;
            end else if (events.d_event) begin
                dbg_demag_ff <= 1'b0;
            end
            dbg_zc_ff <= dbg_zc_ff ^ events.z_event;
        end
    end

    // =========================================================
    // tacho mode and parity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_ff   <= 1'b0;
            rise_en_ff <= 1'b0;
            fall_en_ff <= 1'b0;
            low_ff     <= 6'h00;
        end else begin
            speed_ff   <= (par_ff[PAR_TES_LSB+:2] != 2'h0);
            rise_en_ff <= par_ff[PAR_TES_LSB];
            fall_en_ff <= par_ff[PAR_TES_LSB+1];
            low_ff     <= modes.three_channel_sel ? 6'h00 : par_ff[PAR_OE_LSB+:6];
        end
    end

    // =========================================================
    // outputs
    assign hrdata               = hrdata_ff;
    assign hreadyout            = hreadyout_ff;
    assign hresp                = 1'b0;
    assign phase_u_pwm_pin      = phase_u_ff;
    assign phase_v_pwm_pin      = phase_v_ff;
    assign phase_w_pwm_pin      = phase_w_ff;
    assign debug_demag_pin      = dbg_demag_ff;
    assign debug_zero_cross_pin = dbg_zc_ff;
    assign min_off_busy         = off_busy;
    assign z_sample_strobe      = strobe_ff;
    assign speed_sensor_mode    = speed_ff;
    assign capture_rise_en      = rise_en_ff;
    assign capture_fall_en      = fall_en_ff;
    assign out_active_low       = low_ff;
    assign irq                  = irq_ff;

    // =========================================================
    // assertions
    dbg_pins_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !pwm_ctrl_ff[PWM_DBG_BIT] |=> !debug_demag_pin && !debug_zero_cross_pin)
        else $error("debug pins active with debug off");

    dbg_zc_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pwm_ctrl_ff[PWM_DBG_BIT] && !modes.speed_meas_mode && events.z_event
        |=> debug_zero_cross_pin != $past(debug_zero_cross_pin))
        else $error("zero-cross debug pin missed an event");

    pwm_u_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_u_in && !pwm_ctrl_ff[PWM_EN_U_BIT]) |=> !phase_u_pwm_pin)
        else $error("phase u pwm leaked while disabled");

    off_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (off_load && pwm_ctrl_ff[PWM_OT_LSB+:4] == 4'h0 && presc_ff == 2'h0)
        |=> min_off_busy [*8])
        else $error("minimum off time too short");

    off_sensor_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_fall && modes.sensor_mode_sel && !min_off_busy) |=> !min_off_busy)
        else $error("minimum off time started in sensor mode");

    dly_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pwm_rise && ds_ff == 4'h0 && !dly_busy) |=> !dly_busy)
        else $error("sampling delay started with zero code");

    late_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (dly_done && !pwm_on && modes.z_phase && ds_ff != 4'h0)
        |=> flag_ff ##1 irq == $past(mask_ff))
        else $error("late sample did not raise flag");

    late_demag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!flag_ff && !modes.z_phase) |=> !$rose(flag_ff))
        else $error("flag set by demag sampling");

    late_needs_ds_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(flag_ff) |-> $past(ds_ff) != 4'h0)
        else $error("flag set with zero delay code");

    psc_div4_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (periph_tick && presc_ff[1] && $past(presc_ff[1])) ##1 presc_ff[1] [*2]
        |=> !periph_tick && !$past(periph_tick) && !$past(periph_tick, 2))
        else $error("divide by four ticks too often");

    reset_vals_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> {ds_ff, flag_ff, mask_ff, presc_ff} == CONF_RST
        && pwm_ctrl_ff == PWM_RST && par_ff == PAR_RST)
        else $error("register reset value wrong");

    tacho_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> speed_sensor_mode == ($past(par_ff[PAR_TES_LSB+:2]) != 2'h0)
        && capture_fall_en == $past(par_ff[PAR_TES_LSB+1]))
        else $error("tacho mode decode wrong");

    parity_ign_a: assert property (@(posedge hclk) disable iff (!hresetn)
        modes.three_channel_sel |=> out_active_low == 6'h00)
        else $error("parity not ignored with three channels");

    irq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (flag_ff && !late_clr) |=> flag_ff ##0 irq == $past(mask_ff))
        else $error("flag or irq dropped without clear");

endmodule : mps_top
`default_nettype wire

// ==== mps_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_motor_model
    import mps_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       fire,
    input  wire logic [7:0] on_len,
    input  wire logic [3:0] evt_req,
    output mps_evt_type     events,
    output logic            pwm_on
);
    // =========================================================
    // pwm on-time burst and event pulses
    logic [7:0] cnt_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 8'h00;
            pwm_on <= 1'b0;
            events <= '0;
        end else begin
            events <= mps_evt_type'(evt_req);
            if (fire) begin
                cnt_ff <= on_len;
                pwm_on <= 1'b1;
            end else if (cnt_ff > 8'h01) begin
                cnt_ff <= cnt_ff - 8'h01;
            end else begin
                cnt_ff <= 8'h00;
                pwm_on <= 1'b0;
            end
        end
    end
endmodule : mps_motor_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mps_pkg::*;
;
    logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic         pu = 1'b1, pv = 1'b1, pw = 1'b1;
    logic [31:0]  haddr = '0, hwdata = '0, d, hrdata;
    logic [1:0]   htrans = 2'h0;
    logic [7:0]   on_len = 8'h00;
    logic [3:0]   evt_req = 4'h0;
    mps_mode_type modes = '0;
    mps_evt_type  events;
    logic         hreadyout, hresp, pwm_on, pu_o, pv_o, pw_o, dem, zc, busy, strb, spd, rise, fall, irq;
    logic [5:0]   oal;
    int           n_mismatch = 0, cmp_count = 0, cyc = 0, nb, ns, dv;
    logic [7:0]   ra[8] = '{OFS_PWM, OFS_CONF, OFS_PAR, OFS_PWM, OFS_CONF, OFS_PAR, 8'h20, OFS_IRQ_MASK};
    logic [7:0]   wd[8] = '{8'h00, 8'h00, 8'h00, 8'hA5, 8'h53, 8'hC3, 8'hFF, 8'h01};
    logic [7:0]   re[8] = '{8'h00, 8'h02, 8'h00, 8'hA5, 8'h53, 8'hC3, 8'h00, 8'h01};
    logic [7:0]   ee[6] = '{8'h08, 8'h04, 8'h02, 8'h02, 8'h08, 8'h01};
    logic [1:0]   ex[6] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h3};

    // =========================================================
    // design and far side
    mps_top i_mps_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .events(events), .modes(modes),
        .pwm_u_in(pu), .pwm_v_in(pv), .pwm_w_in(pw), .pwm_on(pwm_on), .phase_u_pwm_pin(pu_o),
        .phase_v_pwm_pin(pv_o), .phase_w_pwm_pin(pw_o), .debug_demag_pin(dem),
        .debug_zero_cross_pin(zc), .min_off_busy(busy), .z_sample_strobe(strb),
        .speed_sensor_mode(spd), .capture_rise_en(rise), .capture_fall_en(fall),
        .out_active_low(oal), .irq(irq));
    mps_motor_model i_mps_motor_model (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .on_len(on_len), .evt_req(evt_req), .events(events), .pwm_on(pwm_on));

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // =========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] w);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= we;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, w};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata ^ {hresp, 31'h0};
    endtask : xfer
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(d, {24'h0, e});
    endtask : rdc
    task automatic watch(input int n);
        nb = 0;
        ns = 0;
        repeat (n) begin
            @(negedge hclk);
            nb += int'(busy === 1'b1);
            ns += int'(strb === 1'b1);
        end
        @(posedge hclk);
    endtask : watch
    task automatic go(input logic [7:0] len, input int n);
        on_len <= len;
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        watch(n);
    endtask : go
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // =========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i > 2) xfer(1'b1, ra[i], wd[i]);
            rdc(ra[i], re[i]);
        end
        xfer(1'b1, OFS_IRQ_MASK, 8'h00);
        xfer(1'b1, OFS_PWM, 8'h00);
        for (int p = 0; p < 4; p++) begin
            xfer(1'b1, OFS_CONF, 8'(p));
            dv = (p == 0) ? 1 : (p == 1) ? 2 : 4;
            go(8'h04, 120);
            chk(32'(nb >= (UNIT_CYC - 1) * dv + 1 && nb <= UNIT_CYC * dv), 1);
            chk(ns, 1);
        end
        modes.sensor_mode_sel <= 1'b1;
        go(8'h04, 60);
        chk(nb, 0);
        modes <= mps_mode_type'(5'h01);
        xfer(1'b1, OFS_CONF, 8'h14);
        go(8'h1E, 40);
        chk({ns[29:0], 1'b0, irq}, {30'd1, 2'h0});
        go(8'h03, 30);
        chk({ns[29:0], 1'b0, irq}, {30'd0, 2'h1});
        rdc(OFS_CONF, 8'h1C);
        rdc(OFS_IRQ_STAT, 8'h01);
        xfer(1'b1, OFS_IRQ_MASK, 8'h00);
        watch(3);
        chk(irq, 0);
        xfer(1'b1, OFS_CONF, 8'h18);
        rdc(OFS_CONF, 8'h10);
        modes.z_phase <= 1'b0;
        xfer(1'b1, OFS_CONF, 8'h14);
        go(8'h03, 30);
        chk(irq, 0);
        modes.z_phase <= 1'b1;
        xfer(1'b1, OFS_CONF, 8'h04);
        go(8'h03, 40);
        chk(irq, 0);
        xfer(1'b1, OFS_PWM, 8'h80);
        for (int i = 0; i < 6; i++) begin
            modes.speed_meas_mode <= (i > 3);
            evt_req <= ee[i][3:0];
            @(posedge hclk);
            evt_req <= 4'h0;
            watch(3);
            chk({dem, zc}, ex[i]);
        end
        xfer(1'b1, OFS_PWM, 8'h10);
        watch(2);
        chk({pu_o, pv_o, pw_o, dem, zc}, 5'h10);
        xfer(1'b1, OFS_PWM, 8'h60);
        watch(2);
        chk({pu_o, pv_o, pw_o}, 3'h3);
        pv <= 1'b0;
        watch(2);
        chk({pu_o, pv_o, pw_o}, 3'h1);
        for (int t = 0; t < 4; t++) begin
            xfer(1'b1, OFS_PAR, 8'(t * 64 + 42));
            watch(2);
            chk({spd, rise, fall, oal}, {t != 0, t[0], t[1], 6'h2A});
        end
        modes.three_channel_sel <= 1'b1;
        watch(2);
        chk(oal, 0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(OFS_PWM, 8'h00);
        rdc(OFS_CONF, 8'h02);
        rdc(OFS_PAR, 8'h00);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
